// file: design/sabd_autobaud.sv
// Auto-baud measurement logic with an AXI4-Lite register slave.
// Assumes rx_line is asynchronous to ref_clk; reset is synchronous high.
//
// Notes on behaviour
// - Receive line times the divisor counter
// - Enable bit starts sequence, receiver held idle
// - Counting starts at first rise after start
// - Fifth rising edge stops count, result kept
// - Completion clears enable, sets receive flag
// - Receive data read clears receive flag
// - Divisor pair is one 16-bit counter
// - Counter advances at one eighth base rate
// - Counter clock is osc/512, /128 or /32
// - Wake on break measures byte after break
// - Counter starts at one
`default_nettype none
module sabd_autobaud #(
    parameter int DIV_WIDTH = 16 // Divisor counter width
) (
    input  wire logic        ref_clk,       // System clock, 100 MHz
    input  wire logic        reset,         // Synchronous reset, high
    input  wire logic        rx_line,       // Serial receive line
    output logic             receive_idle,  // Receiver held idle
    output logic             irq,           // Level interrupt
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready   // Read data ready
);
    // Control bits and divisor storage
    logic                 abd_en_reg;     // Autobaud enable
    logic                 wide_reg;       // Wide divisor select
    logic                 high_reg;       // High speed select
    logic                 wake_reg;       // Wake on break enable
    logic [DIV_WIDTH-1:0] div_reg;        // Divisor pair / counter
    logic [1:0]           status_reg;     // Sticky events
    logic [1:0]           mask_reg;       // Interrupt mask
    sabd_pkg::sabd_state_type state_reg;  // Measurement state
    logic [2:0]           edge_cnt_reg;   // Rising edges seen
    logic                 rx_meta_reg;    // Synchroniser first stage
    logic                 rx_sync_reg;    // Synchroniser second stage
    logic                 rx_prev_reg;    // Previous synced level
    logic [8:0]           pre_cnt_reg;    // Counter clock prescaler
    logic                 tick;           // Counter clock enable
    logic                 rise;           // Rising edge of rx
    logic                 fall;           // Falling edge of rx
    logic                 done;           // Fifth edge seen
    // AXI slave state
    logic                 aw_hold_reg;    // Address captured
    logic                 w_hold_reg;     // Data captured
    logic [7:0]           awaddr_reg;     // Captured write address
    logic [31:0]          wdata_reg;      // Captured write data
    logic [3:0]           wstrb_reg;      // Captured strobes
    logic                 wr_fire;        // Write commits this cycle
    logic                 rd_fire;        // Read taken this cycle
    logic                 rd_rx_data;     // Read hits receive data
    logic                 rd_status;      // Read hits status
    logic [1:0]           status_next;    // Next status value

    // Divider ratio chosen by the two selects
    function automatic logic [8:0] abd_ratio(input logic w, input logic h);
        logic [8:0] r;
        unique case ({w, h})
            2'b00:          r = 9'(sabd_pkg::ABD_DIV_SLOW - 1);
            2'b01, 2'b10:   r = 9'(sabd_pkg::ABD_DIV_MID - 1);
            default:        r = 9'(sabd_pkg::ABD_DIV_FAST - 1);
        endcase
        return r;
    endfunction
    // Receive line synchroniser; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // Reset to the idle mark level so no false edge follows
            {rx_meta_reg, rx_sync_reg, rx_prev_reg} <= 3'b111;
        end else begin
            rx_meta_reg <= rx_line;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end
    // Edges are seen on the synced copy only, so each counts once
    assign rise = rx_sync_reg & ~rx_prev_reg;
    assign fall = ~rx_sync_reg & rx_prev_reg;
    // Prescaler: base clock divided by eight folded into one ratio
    always_ff @(posedge ref_clk) begin
        if (reset || state_reg != sabd_pkg::ABD_COUNT) begin
            pre_cnt_reg <= 9'h000;
        end else if (pre_cnt_reg >= abd_ratio(wide_reg, high_reg)) begin
            pre_cnt_reg <= 9'h000;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 9'h001;
        end
    end
    assign tick = (state_reg == sabd_pkg::ABD_COUNT) &&
                  (pre_cnt_reg >= abd_ratio(wide_reg, high_reg));
    // Fifth rising edge ends the measurement
    assign done = (state_reg == sabd_pkg::ABD_COUNT) && rise &&
                  (edge_cnt_reg == 3'h4);
    // Measurement sequence
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg    <= sabd_pkg::ABD_IDLE;
            edge_cnt_reg <= 3'h0;
        end else begin
            unique case (state_reg)
                sabd_pkg::ABD_IDLE: begin
                    // Enable written: skip a break first if asked
                    if (abd_en_reg) begin
                        state_reg <= wake_reg ? sabd_pkg::ABD_BREAK
                                              : sabd_pkg::ABD_START;
                    end
                end
                sabd_pkg::ABD_BREAK: begin
                    // Break ends at its rising edge; next byte is measured
                    if (!abd_en_reg) begin
                        state_reg <= sabd_pkg::ABD_IDLE;
                    end else if (rise) begin
                        state_reg <= sabd_pkg::ABD_START;
                    end
                end
                sabd_pkg::ABD_START: begin
                    // Falling edge is the start bit
                    if (!abd_en_reg) begin
                        state_reg <= sabd_pkg::ABD_IDLE;
                    end else if (fall) begin
                        state_reg <= sabd_pkg::ABD_FIRST;
                    end
                end
                sabd_pkg::ABD_FIRST: begin
                    if (!abd_en_reg) begin
                        state_reg <= sabd_pkg::ABD_IDLE;
                    end else if (rise) begin
                        state_reg    <= sabd_pkg::ABD_COUNT;
                        edge_cnt_reg <= 3'h1;
                    end
                end
                sabd_pkg::ABD_COUNT: begin
                    if (!abd_en_reg || done) begin
                        state_reg <= sabd_pkg::ABD_IDLE;
                    end else if (rise) begin
                        edge_cnt_reg <= edge_cnt_reg + 3'h1;
                    end
                end
                default: state_reg <= sabd_pkg::ABD_IDLE; // Illegal codes
            endcase
        end
    end
    // Receiver held idle while the sequence runs
    assign receive_idle = (state_reg != sabd_pkg::ABD_IDLE) || abd_en_reg;
    // AXI write address/data capture, either order
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    assign wr_fire       = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            {aw_hold_reg, w_hold_reg} <= 2'b00;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= sabd_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            // Response once both halves are in
            if (wr_fire) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awaddr_reg)
                    sabd_pkg::CTRL_OFFSET, sabd_pkg::DIV_LOW_OFFSET,
                    sabd_pkg::DIV_HIGH_OFFSET, sabd_pkg::RX_DATA_OFFSET,
                    sabd_pkg::STATUS_OFFSET, sabd_pkg::MASK_OFFSET:
                        s_axi_bresp <= sabd_pkg::RESP_OKAY;
                    default: s_axi_bresp <= sabd_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Control bits; hardware clear of enable wins over a same-cycle write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            {wake_reg, high_reg, wide_reg, abd_en_reg} <=
                sabd_pkg::CTRL_RESET;
        end else begin
            if (wr_fire && awaddr_reg == sabd_pkg::CTRL_OFFSET &&
                wstrb_reg[0]) begin
                abd_en_reg <= wdata_reg[sabd_pkg::CTRL_ABD_EN_BIT];
                wide_reg   <= wdata_reg[sabd_pkg::CTRL_WIDE_BIT];
                high_reg   <= wdata_reg[sabd_pkg::CTRL_HIGH_BIT];
                wake_reg   <= wdata_reg[sabd_pkg::CTRL_WAKE_BIT];
            end
            if (done) begin
                abd_en_reg <= 1'b0;
            end
        end
    end
    // Divisor pair: software loads it, the measurement overwrites it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_reg <= DIV_WIDTH'(sabd_pkg::DIV_RESET);
        end else if (state_reg == sabd_pkg::ABD_FIRST && rise) begin
            div_reg <= DIV_WIDTH'(sabd_pkg::DIV_START);
        end else if (tick && !done) begin
            div_reg <= div_reg + DIV_WIDTH'(1);
        end else if (wr_fire && wstrb_reg[0] &&
                     state_reg == sabd_pkg::ABD_IDLE) begin
            // Writes ignored while measuring to keep the count intact
            if (awaddr_reg == sabd_pkg::DIV_LOW_OFFSET) begin
                div_reg[7:0] <= wdata_reg[7:0];
            end else if (awaddr_reg == sabd_pkg::DIV_HIGH_OFFSET) begin
                div_reg[15:8] <= wdata_reg[7:0];
            end
        end
    end

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign rd_rx_data    = rd_fire && s_axi_araddr == sabd_pkg::RX_DATA_OFFSET;
    assign rd_status     = rd_fire && s_axi_araddr == sabd_pkg::STATUS_OFFSET;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= sabd_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= sabd_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                sabd_pkg::CTRL_OFFSET:
                    s_axi_rdata <= {27'h0, receive_idle, wake_reg,
                                    high_reg, wide_reg, abd_en_reg};
                sabd_pkg::DIV_LOW_OFFSET:
                    s_axi_rdata <= {24'h0, div_reg[7:0]};
                sabd_pkg::DIV_HIGH_OFFSET:
                    s_axi_rdata <= {24'h0, div_reg[15:8]};
                sabd_pkg::RX_DATA_OFFSET:
                    s_axi_rdata <= 32'h0000_0000;
                sabd_pkg::STATUS_OFFSET:
                    s_axi_rdata <= {30'h0, status_reg};
                sabd_pkg::MASK_OFFSET:
                    s_axi_rdata <= {30'h0, mask_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= sabd_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Sticky events; a new event wins over a clearing read
    always_comb begin
        status_next = status_reg;
        if (rd_status) begin
            status_next = 2'h0;
        end
        if (rd_rx_data) begin
            status_next[sabd_pkg::STAT_RX_BIT] = 1'b0;
        end
        if (done) begin
            status_next = 2'h3;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_reg <= 2'h0;
            mask_reg   <= sabd_pkg::MASK_RESET;
        end else begin
            status_reg <= status_next;
            if (wr_fire && wstrb_reg[0] &&
                awaddr_reg == sabd_pkg::MASK_OFFSET) begin
                mask_reg <= wdata_reg[1:0];
            end
        end
    end

    // Interrupt while any unmasked status bit is set
    assign irq = |(status_reg & mask_reg);

    // Completion clears the enable and raises the flag next cycle
    property p_done_effects;
        @(posedge ref_clk) disable iff (reset)
        done |=> !abd_en_reg && status_reg[sabd_pkg::STAT_RX_BIT];
    endproperty
    a_done_effects: assert property (p_done_effects)
        else $error("completion did not clear enable or set flag");
    property p_start_one;
        @(posedge ref_clk) disable iff (reset)
        (state_reg == sabd_pkg::ABD_FIRST && rise && abd_en_reg)
            |=> div_reg == DIV_WIDTH'(1) &&
                state_reg == sabd_pkg::ABD_COUNT;
    endproperty
    a_start_one: assert property (p_start_one)
        else $error("counter did not start at one");
    // Setting the enable must leave idle on the very next cycle
    property p_idle_held;
        @(posedge ref_clk) disable iff (reset)
        (abd_en_reg && state_reg == sabd_pkg::ABD_IDLE)
            |=> state_reg != sabd_pkg::ABD_IDLE;
    endproperty
    a_idle_held: assert property (p_idle_held)
        else $error("enable did not start the sequence");
    property p_count_step;
        @(posedge ref_clk) disable iff (reset)
        (tick && !done) |=> div_reg == $past(div_reg) + DIV_WIDTH'(1);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not advance on tick");
    property p_no_count_idle;
        @(posedge ref_clk) disable iff (reset)
        (state_reg == sabd_pkg::ABD_IDLE && !wr_fire) |=> $stable(div_reg);
    endproperty
    a_no_count_idle: assert property (p_no_count_idle)
        else $error("counter moved outside measurement");
    property p_fast_rate;
        @(posedge ref_clk) disable iff (reset)
        (tick && wide_reg && high_reg)
            |-> pre_cnt_reg == 9'(sabd_pkg::ABD_DIV_FAST - 1);
    endproperty
    a_fast_rate: assert property (p_fast_rate)
        else $error("fast counter clock wrong");
    property p_rx_clear;
        @(posedge ref_clk) disable iff (reset)
        (rd_rx_data && !done) |=> !status_reg[sabd_pkg::STAT_RX_BIT];
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("receive data read did not clear flag");
    property p_edge_count;
        @(posedge ref_clk) disable iff (reset)
        done |-> $past(edge_cnt_reg) == 3'h4;
    endproperty
    a_edge_count: assert property (p_edge_count)
        else $error("finished before fifth edge");
    property p_sync_path;
        @(posedge ref_clk) disable iff (reset)
        rise |-> $past(rx_meta_reg) && !rx_prev_reg;
    endproperty
    a_sync_path: assert property (p_sync_path)
        else $error("edge not from synchronised line");
endmodule
`default_nettype wire

// file: design/sabd_pkg.sv
// Package for the serial auto-baud detect block: register map, fields,
// reset values and prescale counts.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
`default_nettype none
package sabd_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET     = 8'h00; // Control bits
    localparam logic [7:0] DIV_LOW_OFFSET  = 8'h04; // Divisor low byte
    localparam logic [7:0] DIV_HIGH_OFFSET = 8'h08; // Divisor high byte
    localparam logic [7:0] RX_DATA_OFFSET  = 8'h0c; // Receive data
    localparam logic [7:0] STATUS_OFFSET   = 8'h10; // Sticky events
    localparam logic [7:0] MASK_OFFSET     = 8'h14; // Interrupt mask
    // Control field positions
    localparam int CTRL_ABD_EN_BIT   = 0; // Autobaud enable
    localparam int CTRL_WIDE_BIT     = 1; // Wide divisor select
    localparam int CTRL_HIGH_BIT     = 2; // High speed select
    localparam int CTRL_WAKE_BIT     = 3; // Wake on break enable
    localparam int CTRL_IDLE_BIT     = 4; // Receive idle, read only
    // Status field positions
    localparam int STAT_RX_BIT       = 0; // Receive flag
    localparam int STAT_DONE_BIT     = 1; // Autobaud done event
    // Reset values
    localparam logic [3:0]  CTRL_RESET   = 4'h0;
    localparam logic [15:0] DIV_RESET    = 16'h0000;
    localparam logic [1:0]  MASK_RESET   = 2'h0;
    // Counter start value after a measurement begins
    localparam logic [15:0] DIV_START    = 16'h0001;
    // Autobaud counter clock dividers from the oscillator
    localparam int ABD_DIV_SLOW = 512; // Both selects low
    localparam int ABD_DIV_MID  = 128; // Exactly one select high
    localparam int ABD_DIV_FAST = 32;  // Both selects high
    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Measurement sequence states
    typedef enum logic [2:0] {
        ABD_IDLE  = 3'b000, // Not measuring
        ABD_BREAK = 3'b001, // Waiting out a break
        ABD_START = 3'b010, // Waiting for start bit
        ABD_FIRST = 3'b011, // Waiting for first rising edge
        ABD_COUNT = 3'b100  // Counting edges two to five
    } sabd_state_type;
endpackage
`default_nettype wire

// file: tb/sabd_sync_tx.sv
// Behavioural remote transmitter that sends the sync byte on the line.
// Assumes the bench calls send_frame; line idles at mark between frames.
`default_nettype none
module sabd_sync_tx (
    input  wire logic ref_clk, // Bench clock
    output var logic  rx_line  // Serial line into the block
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] SYNC_BYTE = 8'h55; // Five rises incl. stop
    initial rx_line = 1'b1; // Idle at mark level

    // Optional break, then start, eight data bits LSB first, stop
    task automatic send_frame(input int bit_cycles, input bit brk);
        logic [9:0] frame;
        frame = {1'b1, SYNC_BYTE, 1'b0};
        @(posedge ref_clk);
        if (brk) begin
            // Long space, then a short mark before the start bit
            rx_line <= 1'b0;
            repeat (13 * bit_cycles) @(posedge ref_clk);
            rx_line <= 1'b1;
            repeat (2 * bit_cycles) @(posedge ref_clk);
        end
        for (int i = 0; i < 10; i++) begin
            rx_line <= frame[i];
            repeat (bit_cycles) @(posedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// file: tb/test_serial_autobaud_detect.sv
// Self-checking bench: register access over AXI4-Lite, sync bytes from
// the transmitter model. Assumes one 100 MHz clock and sync high reset.
`default_nettype none
module test_serial_autobaud_detect;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk, reset, rx_line, receive_idle, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          err_count = 0; // Mismatches seen
    int          checked   = 0; // Comparisons made
    // Control word, bit period in clocks, expected divisor
    // Eight bit periods are 4.5 ticks (300.5 in the 4808-clock row), so tick phase cannot shift count
    localparam int TAB [6][3] = '{'{1, 288, 5}, '{5, 72, 5}, '{3, 72, 5},
        '{7, 18, 5}, '{5, 4808, 301}, '{15, 18, 5}};

    sabd_autobaud DUT (.ref_clk, .reset, .rx_line, .receive_idle, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    sabd_sync_tx u_tx (.ref_clk(ref_clk), .rx_line(rx_line));

    // Free-running 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("Summary: %0d checks, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A wait that ran out counts as a mismatch
    task automatic timeout();
        err_count++;
        $display("Error at %0t: wait ran out, got %h want %h",
                 $time, 1'b0, 1'b1);
        close_out();
    endtask

    // Compare seen against expected, four-state exact
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic       ah, wh, bh;
        logic [1:0] br;
        bh = 1'b0;
        br = 2'h0;
        @(posedge ref_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int n = 0; n < 100 && !bh; n++) begin
            // Readies are steady by mid-cycle, so sample there
            @(negedge ref_clk);
            ah = s_axi_awready;
            wh = s_axi_wready;
            bh = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge ref_clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) s_axi_bready <= 1'b0;
        end
        if (!bh) timeout();
        check({30'h0, br}, {30'h0, er});
    endtask

    // Read: rready held until the data beat is taken
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic ah, rh;
        rh = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int n = 0; n < 100 && !rh; n++) begin
            @(negedge ref_clk);
            ah = s_axi_arready;
            rh = s_axi_rvalid;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge ref_clk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
        end
        if (!rh) timeout();
    endtask

    // Read and compare both data and response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        axi_rd(a, rd, rr);
        check(rd, exp);
        check({30'h0, rr}, {30'h0, er});
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        // Unmapped place, and a sync byte with the enable off
        rd_chk(8'h18, 32'h0, sabd_pkg::RESP_SLVERR);
        u_tx.send_frame(18, 1'b0);
        rd_chk(sabd_pkg::STATUS_OFFSET, 32'h0, sabd_pkg::RESP_OKAY);
        $display("Test idle line done");
        // Unmapped write refused; divisor loads while idle
        axi_wr(8'h18, 32'h0, sabd_pkg::RESP_SLVERR);
        axi_wr(sabd_pkg::DIV_LOW_OFFSET, 32'had, sabd_pkg::RESP_OKAY);
        rd_chk(sabd_pkg::DIV_LOW_OFFSET, 32'had, sabd_pkg::RESP_OKAY);
        axi_wr(sabd_pkg::MASK_OFFSET, 32'h1, sabd_pkg::RESP_OKAY);
        // Every select pair, a count past one byte, and wake on break
        for (int k = 0; k < 6; k++) begin
            axi_wr(sabd_pkg::CTRL_OFFSET, TAB[k][0], 2'h0);
            check({31'h0, receive_idle}, 32'h1);
            u_tx.send_frame(TAB[k][1], TAB[k][0] >= 8);
            for (int n = 0; n < 50 && irq !== 1'b1; n++) @(negedge ref_clk);
            if (irq !== 1'b1) timeout();
            check({31'h0, irq}, 32'h1);
            check({31'h0, receive_idle}, 32'h0);
            rd_chk(sabd_pkg::CTRL_OFFSET, TAB[k][0] - 1, 2'h0);
            rd_chk(sabd_pkg::DIV_LOW_OFFSET, TAB[k][2] % 256, 2'h0);
            rd_chk(sabd_pkg::DIV_HIGH_OFFSET, TAB[k][2] / 256, 2'h0);
            axi_rd(sabd_pkg::RX_DATA_OFFSET, rd, rr);
            @(negedge ref_clk);
            check({31'h0, irq}, 32'h0);
            rd_chk(sabd_pkg::STATUS_OFFSET, 32'h2, 2'h0);
            $display("Test measurement %0d done", k);
        end
        close_out();
    end
endmodule
`default_nettype wire
